// ==== common/pm_ctrl_if.sv ====
interface pm_ctrl_if;
  import power_mgmt_pkg::*;

  logic         state_wr;
  power_state_t state_wdata;
  logic         wake_en_wr;
  logic         wake_en_wdata;
  power_state_t state;
  logic         wake_en;
  logic         in_d3hot;
  logic         d3_exit;

  modport regs (
    output state_wr, state_wdata, wake_en_wr, wake_en_wdata,
    input  state, wake_en, in_d3hot, d3_exit
  );

  modport ctrl (
    input  state_wr, state_wdata, wake_en_wr, wake_en_wdata,
    output state, wake_en, in_d3hot, d3_exit
  );

endinterface : pm_ctrl_if

// ==== common/power_mgmt_pkg.sv ====
package power_mgmt_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          CFG_ADDR_W         = 12;
  localparam logic [11:0] CAP_INFO_OFFSET    = 12'h0a0;
  localparam logic [11:0] CTRL_STATUS_OFFSET = 12'h0a4;
  localparam logic [31:0] CAP_INFO_RESET     = 32'h7803c001;
  localparam logic [31:0] CTRL_STATUS_RESET  = 32'h00000008;

  // ****************************************************************
  // power_capability_info fields
  // ****************************************************************
  localparam int WAKE_SUP_MSB      = 31;
  localparam int WAKE_SUP_LSB      = 27;
  localparam int DEEP_DOZE_BIT     = 26;
  localparam int LIGHT_SLEEP_BIT   = 25;
  localparam int AUXILIARY_CURRENT_MSB       = 24;
  localparam int AUXILIARY_CURRENT_LSB       = 22;
  localparam int DEV_INIT_BIT      = 21;
  localparam int CAP_RSVD_BIT      = 20;
  localparam int WAKE_CLK_BIT      = 19;
  localparam int VERSION_MSB       = 18;
  localparam int VERSION_LSB       = 16;
  localparam int NEXT_PTR_MSB      = 15;
  localparam int NEXT_PTR_LSB      = 8;
  localparam int CAPABILITY_IDENTIFIER_MSB        = 7;
  localparam int CAPABILITY_IDENTIFIER_LSB        = 0;

  localparam logic [4:0] WAKE_SUP_DEFAULT = CAP_INFO_RESET[WAKE_SUP_MSB:WAKE_SUP_LSB];
  localparam logic       STATE_ABSENT     = 1'h0;
  localparam logic [2:0] AUXILIARY_CURRENT_VALUE    = 3'h0;
  localparam logic [2:0] VERSION_VALUE    = 3'h3;
  localparam logic [7:0] NEXT_PTR_VALUE   = 8'hc0;
  localparam logic [7:0] CAPABILITY_IDENTIFIER_VALUE     = 8'h01;

  // ****************************************************************
  // power_control_status fields
  // ****************************************************************
  localparam int POWER_DATA_MSB    = 31;
  localparam int POWER_DATA_LSB    = 24;
  localparam int CS_RSVD_HI_MSB    = 23;
  localparam int CS_RSVD_HI_LSB    = 16;
  localparam int WAKE_STATUS_BIT   = 15;
  localparam int DATA_SCALE_MSB    = 14;
  localparam int DATA_SCALE_LSB    = 13;
  localparam int DATA_SEL_MSB      = 12;
  localparam int DATA_SEL_LSB      = 9;
  localparam int WAKE_ENABLE_BIT   = 8;
  localparam int NO_SOFT_RESET_BIT = 3;
  localparam int POWER_STATE_MSB   = 1;
  localparam int POWER_STATE_LSB   = 0;
  localparam int STATE_LANE        = 0;
  localparam int WAKE_EN_LANE      = 1;

  localparam logic [7:0] POWER_DATA_VALUE    = 8'h00;
  localparam logic [1:0] DATA_SCALE_VALUE    = 2'h0;
  localparam logic [3:0] DATA_SEL_VALUE      = 4'h0;
  localparam logic       NO_SOFT_RESET_VALUE = CTRL_STATUS_RESET[NO_SOFT_RESET_BIT];
  localparam logic       WAKE_ENABLE_RESET   = CTRL_STATUS_RESET[WAKE_ENABLE_BIT];

  typedef enum logic [1:0] {
    PS_D0    = 2'h0,
    PS_D1    = 2'h1,
    PS_D2    = 2'h2,
    PS_D3HOT = 2'h3
  } power_state_t;

  localparam power_state_t POWER_STATE_RESET =
    power_state_t'(CTRL_STATUS_RESET[POWER_STATE_MSB:POWER_STATE_LSB]);

endpackage : power_mgmt_pkg

// ==== rtl/power_mgmt_capability_regs.sv ====
// Functional notes
// - wake support field bits 31:27 resets to 01111, loaded from eeprom configuration
// - without eeprom information wake support covers states down to d3hot only
// - deep doze support bit 26 always reads zero
// - light sleep support bit 25 always reads zero
// - auxiliary current field 24:22 always reads 000, self powered
// - device specific initialization bit 21 hardwired to zero
// - wake clock bit 19 and reserved bit 20 read zero
// - capability version field 18:16 reads 011
// - next capability pointer 15:8 reads 0xc0
// - capability identifier 7:0 reads 0x01
// - power data byte 31:24 of control word reads 0x00
// - reserved byte 23:16 of control word reads zero
// - wake status bit 15 reads zero, writing one does nothing
// - power data scale field 14:13 reads zero
// - power data select field 12:9 reads zero
// - reset values 0x7803_c001 and 0x0000_0008 for the two words
// - writable power state 1:0, 00 d0 to 11 d3hot, unsupported writes ignored
// - wake enable bit 8 read/write, gates wake signal, cleared from power-off
// - no soft reset bit 3 always reads one
module power_mgmt_capability_regs
  import power_mgmt_pkg::*;
#(
  parameter int ADDR_W = CFG_ADDR_W
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  // configuration access
  input  wire logic [ADDR_W-1:0] i_cfg_addr,
  input  wire logic              i_cfg_rd,
  input  wire logic              i_cfg_wr,
  input  wire logic [3:0]        i_cfg_be,
  input  wire logic [31:0]       i_cfg_wdata,
  output      logic [31:0]       o_cfg_rdata,
  output      logic              o_cfg_ack,
  // eeprom configuration
  input  wire logic              i_ee_load,
  input  wire logic [4:0]        i_ee_wake_support,
  // wake event from the board
  input  wire logic              i_wake_event,
  // power state to the bridge core
  output      logic [1:0]        o_power_state,
  output      logic              o_low_power,
  output      logic              o_d3hot_exit,
  output      logic              o_wake_enable,
  output      logic              o_wake_request
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // the map needs at least eight address bits and offsets hold twelve
  generate
    if (ADDR_W < 8 || ADDR_W > CFG_ADDR_W) begin : g_bad_addr_w
      $error("ADDR_W must lie between 8 and CFG_ADDR_W");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [31:0] cap_word;
  logic [31:0] cs_word;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [4:0]  wake_sup_r;
  logic [4:0]  wake_sup_nxt;
  logic        wake_meta_r;
  logic        wake_sync_r;
  logic        wake_req_r;
  logic        wake_req_nxt;

  pm_ctrl_if pm ();

  // ****************************************************************
  // wake event synchroniser
  // ****************************************************************
  // the board pin is asynchronous; only the second stage is looked at
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wake_meta_r <= 1'h0;
      wake_sync_r <= 1'h0;
    end else begin
      wake_meta_r <= i_wake_event;
      wake_sync_r <= wake_meta_r;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  // configuration accesses are whole dwords, the low two bits are ignored
  wire logic cap_hit = (i_cfg_addr[ADDR_W-1:2] == CAP_INFO_OFFSET[ADDR_W-1:2]);
  wire logic cs_hit  = (i_cfg_addr[ADDR_W-1:2] == CTRL_STATUS_OFFSET[ADDR_W-1:2]);

  wire logic cs_write   = i_cfg_wr && cs_hit;
  wire logic any_access = i_cfg_rd || i_cfg_wr;

  // ****************************************************************
  // write decode
  // ****************************************************************
  // only the byte lanes holding power state and wake enable are steered;
  // every other lane of either word is dropped without effect
  wire logic state_lane_wr = cs_write && i_cfg_be[STATE_LANE];
  wire logic wake_lane_wr  = cs_write && i_cfg_be[WAKE_EN_LANE];

  wire logic [1:0] state_field = i_cfg_wdata[POWER_STATE_MSB:POWER_STATE_LSB];
  wire logic       wake_field  = i_cfg_wdata[WAKE_ENABLE_BIT];

  assign pm.state_wr      = state_lane_wr;
  assign pm.state_wdata   = power_state_t'(state_field);
  assign pm.wake_en_wr    = wake_lane_wr;
  assign pm.wake_en_wdata = wake_field;

  // a one written to the wake status bit shares lane one with wake enable
  // but no status flop exists, so it is simply not wired anywhere

  // ****************************************************************
  // power state and wake enable registers
  // ****************************************************************
  power_state_ctrl u_state_ctrl (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .pm        (pm.ctrl)
  );

  // ****************************************************************
  // wake support field
  // ****************************************************************
  // until the eeprom controller delivers a value the field stays at its
  // reset figure, which claims wake support down to d3hot only
  assign wake_sup_nxt = i_ee_load ? i_ee_wake_support : wake_sup_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wake_sup_r <= WAKE_SUP_DEFAULT;
    end else begin
      wake_sup_r <= wake_sup_nxt;
    end
  end

  // ****************************************************************
  // power_capability_info word
  // ****************************************************************
  // every field but wake support is a constant, so config writes to this
  // word can never disturb it
  assign cap_word[WAKE_SUP_MSB:WAKE_SUP_LSB] = wake_sup_r;
  assign cap_word[DEEP_DOZE_BIT]             = STATE_ABSENT;
  assign cap_word[LIGHT_SLEEP_BIT]           = STATE_ABSENT;
  assign cap_word[AUXILIARY_CURRENT_MSB:AUXILIARY_CURRENT_LSB]   = AUXILIARY_CURRENT_VALUE;
  assign cap_word[DEV_INIT_BIT]              = 1'h0;
  assign cap_word[CAP_RSVD_BIT]              = 1'h0;
  assign cap_word[WAKE_CLK_BIT]              = 1'h0;
  assign cap_word[VERSION_MSB:VERSION_LSB]   = VERSION_VALUE;
  assign cap_word[NEXT_PTR_MSB:NEXT_PTR_LSB] = NEXT_PTR_VALUE;
  assign cap_word[CAPABILITY_IDENTIFIER_MSB:CAPABILITY_IDENTIFIER_LSB]     = CAPABILITY_IDENTIFIER_VALUE;

  // ****************************************************************
  // power_control_status word
  // ****************************************************************
  localparam int LOW_RSVD_MSB = WAKE_ENABLE_BIT - 1;
  localparam int LOW_RSVD_LSB = NO_SOFT_RESET_BIT + 1;
  localparam int MID_RSVD_BIT = POWER_STATE_MSB + 1;

  assign cs_word[POWER_DATA_MSB:POWER_DATA_LSB] = POWER_DATA_VALUE;
  assign cs_word[CS_RSVD_HI_MSB:CS_RSVD_HI_LSB] = '0;
  assign cs_word[WAKE_STATUS_BIT]               = 1'h0;
  assign cs_word[DATA_SCALE_MSB:DATA_SCALE_LSB] = DATA_SCALE_VALUE;
  assign cs_word[DATA_SEL_MSB:DATA_SEL_LSB]     = DATA_SEL_VALUE;
  assign cs_word[WAKE_ENABLE_BIT]               = pm.wake_en;
  assign cs_word[LOW_RSVD_MSB:LOW_RSVD_LSB]     = '0;
  assign cs_word[NO_SOFT_RESET_BIT]             = NO_SOFT_RESET_VALUE;
  assign cs_word[MID_RSVD_BIT]                  = 1'h0;
  assign cs_word[POWER_STATE_MSB:POWER_STATE_LSB] = pm.state;

  // ****************************************************************
  // read path
  // ****************************************************************
  // an unmapped dword reads as zero; a read in the same cycle as a write
  // returns the value from before that write
  assign rd_mux = cap_hit ? cap_word :
                  cs_hit  ? cs_word  :
                  '0;

  assign rdata_nxt = i_cfg_rd ? rd_mux : '0;
  assign ack_nxt   = any_access;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_r <= '0;
      ack_r   <= 1'h0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // ****************************************************************
  // wake signalling
  // ****************************************************************
  // wake enable gates the board event; the request is a registered level
  assign wake_req_nxt = pm.wake_en && wake_sync_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wake_req_r <= 1'h0;
    end else begin
      wake_req_r <= wake_req_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_cfg_rdata    = rdata_r;
  assign o_cfg_ack      = ack_r;
  assign o_power_state  = pm.state;
  assign o_low_power    = pm.in_d3hot;
  assign o_d3hot_exit   = pm.d3_exit;
  assign o_wake_enable  = pm.wake_en;
  assign o_wake_request = wake_req_r;

endmodule : power_mgmt_capability_regs

// ==== rtl/power_state_ctrl.sv ====
module power_state_ctrl
  import power_mgmt_pkg::*;
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  // register side
  pm_ctrl_if.ctrl   pm
);

  // ****************************************************************
  // next-state selection
  // ****************************************************************
  // d1 and d2 do not exist here, so a request for them keeps the old state
  wire logic state_supported = (pm.state_wdata == PS_D0) || (pm.state_wdata == PS_D3HOT);
  wire logic state_take      = pm.state_wr && state_supported;

  power_state_t state_r;
  power_state_t state_nxt;
  logic         wake_en_r;
  logic         wake_en_nxt;
  logic         in_d3hot_r;
  logic         d3_exit_r;

  assign state_nxt   = state_take ? pm.state_wdata : state_r;
  assign wake_en_nxt = pm.wake_en_wr ? pm.wake_en_wdata : wake_en_r;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r    <= POWER_STATE_RESET;
      wake_en_r  <= WAKE_ENABLE_RESET;
      in_d3hot_r <= 1'h0;
      d3_exit_r  <= 1'h0;
    end else begin
      state_r    <= state_nxt;
      wake_en_r  <= wake_en_nxt;
      in_d3hot_r <= (state_nxt == PS_D3HOT);
      d3_exit_r  <= (state_r == PS_D3HOT) && (state_nxt == PS_D0);
    end
  end

  assign pm.state    = state_r;
  assign pm.wake_en  = wake_en_r;
  assign pm.in_d3hot = in_d3hot_r;
  assign pm.d3_exit  = d3_exit_r;

endmodule : power_state_ctrl

// ==== testbench/power_mgmt_capability_regs_checker.sv ====
module power_mgmt_capability_regs_checker
  import power_mgmt_pkg::*;
#(
  parameter int ADDR_W = CFG_ADDR_W
) (
  // watched ports
  input wire logic              i_sys_clk,
  input wire logic              i_reset,
  input wire logic [ADDR_W-1:0] i_cfg_addr,
  input wire logic              i_cfg_rd,
  input wire logic              i_cfg_wr,
  input wire logic [3:0]        i_cfg_be,
  input wire logic [31:0]       i_cfg_wdata,
  input wire logic [31:0]       o_cfg_rdata,
  input wire logic              o_cfg_ack,
  input wire logic              i_ee_load,
  input wire logic [4:0]        i_ee_wake_support,
  input wire logic [1:0]        o_power_state,
  input wire logic              o_low_power,
  input wire logic              o_d3hot_exit,
  input wire logic              o_wake_enable,
  input wire logic              o_wake_request
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire cap_sel = i_cfg_addr == CAP_INFO_OFFSET[ADDR_W-1:0];
  wire ctl_sel = i_cfg_addr == CTRL_STATUS_OFFSET[ADDR_W-1:0];
  // only 00 and 11 are supported states, so equal bits mark a legal request
  wire st_wr   = i_cfg_wr && ctl_sel && i_cfg_be[0] && (i_cfg_wdata[1] == i_cfg_wdata[0]);

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  // ****************************************************************
  // assertions
  // ****************************************************************
  ack_timing_a:
    assert property ((i_cfg_rd || i_cfg_wr) |=> o_cfg_ack) else $error("ack missing");
  cap_fixed_a:
    assert property ((i_cfg_rd && cap_sel) |=> o_cfg_rdata[26:0] == 27'h003c001)
      else $error("capability word constant bits wrong");
  ee_load_a:
    assert property (i_ee_load ##1 (i_cfg_rd && cap_sel) |=>
      o_cfg_rdata[31:27] == $past(i_ee_wake_support, 2)) else $error("wake support not loaded");
  ctrl_read_a:
    assert property ((i_cfg_rd && ctl_sel) |=> {o_cfg_rdata[31:9], o_cfg_rdata[7:2]} ==
      {23'h0, 6'h02} && o_cfg_rdata[1:0] == $past(o_power_state) &&
      o_cfg_rdata[8] == $past(o_wake_enable)) else $error("control word read wrong");
  state_write_a:
    assert property (st_wr |=> o_power_state == $past(i_cfg_wdata[1:0]))
      else $error("power state not written");
  state_hold_a:
    assert property (!st_wr |=> $stable(o_power_state)) else $error("power state moved");
  wake_write_a:
    assert property ((i_cfg_wr && ctl_sel && i_cfg_be[1]) |=>
      o_wake_enable == $past(i_cfg_wdata[8])) else $error("wake enable not written");
  low_power_a:
    assert property ((st_wr && i_cfg_wdata[1]) |=> o_low_power) else $error("low power missing");
  d3_exit_a:
    assert property ((st_wr && !i_cfg_wdata[1] && o_power_state == 2'h3) |=> o_d3hot_exit)
      else $error("d3hot exit pulse missing");

  cover property (st_wr ##1 o_d3hot_exit);
  cover property (i_ee_load ##1 i_cfg_rd);
  cover property (o_wake_request);
endmodule : power_mgmt_capability_regs_checker

// ==== testbench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import power_mgmt_pkg::*;

  logic        i_sys_clk, i_reset, i_cfg_rd, i_cfg_wr, i_ee_load, i_wake_event;
  logic [11:0] i_cfg_addr;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata, o_cfg_rdata;
  logic [4:0]  i_ee_wake_support;
  logic [1:0]  o_power_state;
  logic        o_cfg_ack, o_low_power, o_d3hot_exit, o_wake_enable, o_wake_request;
  int          n_fail, cmp_count;

  power_mgmt_capability_regs uut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_cfg_addr(i_cfg_addr),
    .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack),
    .i_ee_load(i_ee_load), .i_ee_wake_support(i_ee_wake_support),
    .i_wake_event(i_wake_event), .o_power_state(o_power_state), .o_low_power(o_low_power),
    .o_d3hot_exit(o_d3hot_exit), .o_wake_enable(o_wake_enable),
    .o_wake_request(o_wake_request)
  );

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk

  // one request per call; the leading wait keeps two calls from driving in one step
  task automatic cfg_acc(input logic rd, input logic [11:0] a, input logic [3:0] be,
                         input logic [31:0] wd);
    @(negedge i_sys_clk);
    i_cfg_rd    = rd;
    i_cfg_wr    = !rd;
    i_cfg_addr  = a;
    i_cfg_be    = be;
    i_cfg_wdata = wd;
    @(negedge i_sys_clk);
    i_cfg_rd = 1'h0;
    i_cfg_wr = 1'h0;
    chk("ack", 32'h1, {31'h0, o_cfg_ack});
  endtask : cfg_acc

  task automatic cfg_read(input logic [11:0] a, input logic [31:0] exp);
    cfg_acc(1'h1, a, 4'h0, 32'h0);
    chk("rdata", exp, o_cfg_rdata);
  endtask : cfg_read

  task automatic final_report;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    i_sys_clk = 1'h0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    repeat (5000) @(posedge i_sys_clk);
    n_fail++;
    final_report;
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {i_reset, i_cfg_rd, i_cfg_wr, i_ee_load, i_wake_event} = 5'h10;
    {i_cfg_addr, i_cfg_be, i_cfg_wdata, i_ee_wake_support} = '0;
    repeat (12) @(negedge i_sys_clk);
    i_reset = 1'h0;
    cfg_read(12'h0a0, 32'h7803c001);
    cfg_read(12'h0a4, 32'h00000008);
    cfg_acc(1'h0, 12'h0a0, 4'hf, 32'hffffffff);
    cfg_read(12'h0a0, 32'h7803c001);
    cfg_acc(1'h0, 12'h0a4, 4'hf, 32'hffffffff);
    chk("low_power", 32'h1, {31'h0, o_low_power});
    chk("power_state", 32'h3, {30'h0, o_power_state});
    chk("wake_enable", 32'h1, {31'h0, o_wake_enable});
    cfg_read(12'h0a4, 32'h0000010b);
    for (int ps = 1; ps < 3; ps++) begin
      cfg_acc(1'h0, 12'h0a4, 4'h1, 32'(ps));
      cfg_read(12'h0a4, 32'h0000010b);
    end
    cfg_acc(1'h0, 12'h0a4, 4'h2, 32'h0);
    cfg_read(12'h0a4, 32'h0000000b);
    cfg_acc(1'h0, 12'h0a4, 4'h1, 32'h0);
    chk("d3hot_exit", 32'h1, {31'h0, o_d3hot_exit});
    cfg_read(12'h0a4, 32'h00000008);
    cfg_read(12'h0a8, 32'h0);
    @(negedge i_sys_clk);
    i_ee_wake_support = 5'h1f;
    i_ee_load         = 1'h1;
    // the read follows the load by one cycle, so the checker sees the pair
    fork
      cfg_read(12'h0a0, 32'hf803c001);
      begin
        @(negedge i_sys_clk);
        i_ee_load = 1'h0;
      end
    join
    cfg_acc(1'h0, 12'h0a4, 4'h2, 32'h100);
    i_wake_event = 1'h1;
    repeat (4) @(negedge i_sys_clk);
    chk("wake_request", 32'h1, {31'h0, o_wake_request});
    cfg_acc(1'h0, 12'h0a4, 4'h2, 32'h0);
    repeat (2) @(negedge i_sys_clk);
    chk("wake_request", 32'h0, {31'h0, o_wake_request});
    i_wake_event = 1'h0;
    cfg_acc(1'h0, 12'h0a4, 4'h3, 32'h103);
    i_reset = 1'h1;
    repeat (2) @(negedge i_sys_clk);
    i_reset = 1'h0;
    chk("power_state", 32'h0, {30'h0, o_power_state});
    chk("wake_enable", 32'h0, {31'h0, o_wake_enable});
    chk("low_power", 32'h0, {31'h0, o_low_power});
    cfg_read(12'h0a4, 32'h00000008);
    cfg_read(12'h0a0, 32'h7803c001);
    final_report;
  end
endmodule : testbench

bind power_mgmt_capability_regs power_mgmt_capability_regs_checker #(.ADDR_W(ADDR_W)) chk_i (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_cfg_addr(i_cfg_addr), .i_cfg_rd(i_cfg_rd),
  .i_cfg_wr(i_cfg_wr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .i_ee_load(i_ee_load),
  .i_ee_wake_support(i_ee_wake_support), .o_power_state(o_power_state),
  .o_low_power(o_low_power), .o_d3hot_exit(o_d3hot_exit), .o_wake_enable(o_wake_enable),
  .o_wake_request(o_wake_request)
);
